// File: dv/dtc_core_model.sv
`timescale 1ns/100ps
module dtc_core_model
    import dtc_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Register bus
    output logic [7:0] sfr_addr = 8'h00,
    output logic sfr_wr = 1'h0,
    output logic [7:0] sfr_wdata = 8'h00,
    output logic sfr_rd = 1'h0,
    input wire logic [7:0] sfr_rdata,
    // Service acknowledges
    output logic ack_first = 1'h0,
    output logic ack_second = 1'h0
);
    // Idle address and data are inverted so a stale value never looks valid
    task automatic wr(input logic [7:0] a, d);
        @(posedge mclk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'h1;
        @(posedge mclk);
        sfr_wr <= 1'h0;
        sfr_addr <= ~a;
        sfr_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        sfr_addr <= a;
        sfr_rd <= 1'h1;
        @(posedge mclk);
        sfr_rd <= 1'h0;
        sfr_addr <= ~a;
        @(negedge mclk);
        d = sfr_rdata;
    endtask
    task automatic ack(input logic f, s);
        @(posedge mclk);
        ack_first <= f;
        ack_second <= s;
        @(posedge mclk);
        ack_first <= 1'h0;
        ack_second <= 1'h0;
    endtask
endmodule

// File: dv/dtc_timer_core_properties.sv
`timescale 1ns/100ps
module dtc_timer_core_checker
    import dtc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Register bus
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_rdata,
    // Acknowledges and flags
    input wire logic vector_ack_first,
    input wire logic vector_ack_second,
    input wire logic overflow_flag_first,
    input wire logic overflow_flag_second
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    wire wr_ctl = sfr_wr && sfr_addr == ADDR_CONTROL;
    wire rd_ctl = sfr_rd && sfr_addr == ADDR_CONTROL;
    wire mapped = sfr_addr >= ADDR_CONTROL && sfr_addr <= ADDR_HIGH_SECOND;
    sequence ctl_wr_rd;
        wr_ctl ##1 !sfr_wr ##1 rd_ctl && !sfr_wr;
    endsequence
    a_reset_clears: assert property (disable iff (1'b0) srst |=> !overflow_flag_first && !overflow_flag_second)
        else $error("flags not cleared by reset");
    a_unmapped_zero: assert property (sfr_rd && !mapped |=> sfr_rdata == UNMAPPED_READ)
        else $error("unmapped read not zero");
    a_ctl_low_zero: assert property (rd_ctl |=> sfr_rdata[3:0] == 4'h0)
        else $error("control low bits not zero");
    a_flag1_mirror: assert property (rd_ctl |=> sfr_rdata[5] == $past(overflow_flag_first))
        else $error("control bit 5 differs from first flag");
    a_flag2_mirror: assert property (rd_ctl |=> sfr_rdata[7] == $past(overflow_flag_second))
        else $error("control bit 7 differs from second flag");
    a_flag1_cause: assert property ($fell(overflow_flag_first) |->
        $past(vector_ack_first) || $past(wr_ctl && !sfr_wdata[5]) || $past(srst))
        else $error("first flag dropped without cause");
    a_flag2_cause: assert property ($fell(overflow_flag_second) |->
        $past(vector_ack_second) || $past(wr_ctl && !sfr_wdata[7]) || $past(srst))
        else $error("second flag dropped without cause");
    a_rdata_holds: assert property (!sfr_rd |=> $stable(sfr_rdata))
        else $error("read data moved without a read");
    a_run_readback: assert property (ctl_wr_rd |=> sfr_rdata[6] == $past(sfr_wdata[6], 3)
        && sfr_rdata[4] == $past(sfr_wdata[4], 3))
        else $error("run bits not read back");
endmodule

bind dtc_timer_core dtc_timer_core_checker u_chk (.mclk(mclk), .srst(srst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .vector_ack_first(vector_ack_first), .vector_ack_second(vector_ack_second),
    .overflow_flag_first(overflow_flag_first), .overflow_flag_second(overflow_flag_second));

// File: dv/test_dual_timer_counter_core.sv
`timescale 1ns/100ps
module test_dual_timer_counter_core import dtc_pkg::*;;
    typedef struct {logic [7:0] t, mode, lo, hi; logic gp; int n; logic [7:0] elo, ehi; logic ef;} dtc_row_s;
    logic mclk = 1'h0;
    logic srst = 1'h1;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, d;
    logic sfr_wr, sfr_rd, ack1, ack2, of1, of2, f;
    logic [1:0] cin = 2'h0;
    logic [1:0] gpin = 2'h0;
    int fails = 0;
    int check_count = 0;
    dtc_row_s rows [10] = '{
        '{8'h0, 8'h01, 8'hFE, 8'hFF, 1'h0, 4, 8'h02, 8'h00, 1'h1},
        '{8'h0, 8'h00, 8'hFE, 8'h05, 1'h0, 4, 8'hE2, 8'h06, 1'h0},
        '{8'h0, 8'h00, 8'h1F, 8'hFF, 1'h0, 3, 8'h02, 8'h00, 1'h1},
        '{8'h0, 8'h02, 8'hFE, 8'h40, 1'h0, 4, 8'h42, 8'h40, 1'h1},
        '{8'h0, 8'h09, 8'h10, 8'h00, 1'h0, 5, 8'h10, 8'h00, 1'h0},
        '{8'h0, 8'h09, 8'h10, 8'h00, 1'h1, 5, 8'h15, 8'h00, 1'h0},
        '{8'h0, 8'h03, 8'hFE, 8'h20, 1'h0, 4, 8'h02, 8'h20, 1'h1},
        '{8'h1, 8'h10, 8'hFE, 8'hFF, 1'h0, 4, 8'h02, 8'h00, 1'h1},
        '{8'h1, 8'h30, 8'h10, 8'h00, 1'h0, 5, 8'h10, 8'h00, 1'h0},
        '{8'h1, 8'h90, 8'h10, 8'h00, 1'h1, 5, 8'h15, 8'h00, 1'h0}};
    dtc_timer_core dut (.mclk(mclk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
        .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .vector_ack_first(ack1), .vector_ack_second(ack2),
        .count_input_first(cin[0]), .count_input_second(cin[1]), .gate_pin_first(gpin[0]),
        .gate_pin_second(gpin[1]), .overflow_flag_first(of1), .overflow_flag_second(of2));
    dtc_core_model core (.mclk(mclk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
        .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .ack_first(ack1), .ack_second(ack2));
    initial begin
        forever #4 mclk = ~mclk;
    end
    task automatic check(input logic [7:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        if (fails == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #50000;
        fails++;
        close_out;
    end
    initial begin
        repeat (4) @(posedge mclk);
        srst <= 1'h0;
        foreach (rows[i]) begin
            core.wr(ADDR_CONTROL, 8'h00);
            core.wr(ADDR_LOW_FIRST + rows[i].t, rows[i].lo);
            core.wr(ADDR_HIGH_FIRST + rows[i].t, rows[i].hi);
            gpin <= {2{rows[i].gp}};
            core.wr(ADDR_MODE, rows[i].mode);
            core.wr(ADDR_CONTROL, rows[i].t[0] ? 8'h40 : 8'h10);
            repeat (rows[i].n - 2) @(posedge mclk);
            @(negedge mclk) f = rows[i].t[0] ? of2 : of1;
            core.wr(ADDR_CONTROL, 8'h00);
            check({7'h00, f}, {7'h00, rows[i].ef});
            core.rd(ADDR_LOW_FIRST + rows[i].t, d);
            check(d, rows[i].elo);
            core.rd(ADDR_HIGH_FIRST + rows[i].t, d);
            check(d, rows[i].ehi);
        end
        // Pin toggles at the fastest legal rate, one cycle high and one low
        for (int t = 0; t < 2; t++) begin
            core.wr(ADDR_MODE, t ? 8'h50 : 8'h05);
            core.wr(ADDR_LOW_FIRST + 8'(t), 8'h00);
            core.wr(ADDR_CONTROL, t ? 8'h40 : 8'h10);
            repeat (4) begin
                @(posedge mclk) cin[t] <= 1'h1;
                @(posedge mclk) cin[t] <= 1'h0;
            end
            repeat (4) @(posedge mclk);
            core.wr(ADDR_CONTROL, 8'h00);
            core.rd(ADDR_LOW_FIRST + 8'(t), d);
            check(d, 8'h04);
        end
        // Split high byte runs on the second run bit and owns the second flag
        core.wr(ADDR_CONTROL, 8'h00);
        core.wr(ADDR_MODE, 8'h03);
        core.wr(ADDR_HIGH_FIRST, 8'hFE);
        core.wr(ADDR_CONTROL, 8'h50);
        repeat (2) @(posedge mclk);
        @(negedge mclk) check({7'h00, of2}, 8'h01);
        core.wr(ADDR_CONTROL, 8'h00);
        core.rd(ADDR_HIGH_FIRST, d);
        check(d, 8'h02);
        core.wr(ADDR_CONTROL, 8'hF0);
        core.rd(ADDR_CONTROL, d);
        check(d, 8'hF0);
        core.ack(1'h1, 1'h1);
        @(negedge mclk) check({6'h00, of2, of1}, 8'h00);
        core.wr(ADDR_MODE, 8'hA5);
        core.rd(ADDR_MODE, d);
        check(d, 8'hA5);
        @(posedge mclk) srst <= 1'h1;
        @(posedge mclk) srst <= 1'h0;
        for (int a = 8'h88; a <= 8'h8E; a++) begin
            core.rd(8'(a), d);
            check(d, 8'h00);
        end
        close_out;
    end
endmodule

// File: hdl/dtc_pkg.sv
package dtc_pkg;
    // Register addresses on the core's special function register bus
    localparam logic [7:0] ADDR_CONTROL = 8'h88;
    localparam logic [7:0] ADDR_MODE = 8'h89;
    localparam logic [7:0] ADDR_LOW_FIRST = 8'h8A;
    localparam logic [7:0] ADDR_LOW_SECOND = 8'h8B;
    localparam logic [7:0] ADDR_HIGH_FIRST = 8'h8C;
    localparam logic [7:0] ADDR_HIGH_SECOND = 8'h8D;

    // Reset values
    localparam logic [7:0] RESET_CONTROL = 8'h00;
    localparam logic [7:0] RESET_MODE = 8'h00;
    localparam logic [7:0] RESET_COUNT = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Control register fields
    localparam int CTL_OVF_SECOND = 7;
    localparam int CTL_RUN_SECOND = 6;
    localparam int CTL_OVF_FIRST = 5;
    localparam int CTL_RUN_FIRST = 4;

    // Mode register fields, first timer at offset 0, second at offset 4
    localparam int MODE_FIELD_SECOND = 4;
    localparam int MODE_FIELD_FIRST = 0;
    localparam int MODE_SEL_LOW = 0;
    localparam int MODE_SEL_HIGH = 1;
    localparam int MODE_COUNTER_SEL = 2;
    localparam int MODE_GATE = 3;

    // Mode field encodings
    localparam logic [1:0] MODE_PRESCALED = 2'h0;
    localparam logic [1:0] MODE_SIXTEEN = 2'h1;
    localparam logic [1:0] MODE_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;

    // Prescaler held in the low byte in the 13-bit mode
    localparam int PRESCALE_BITS = 5;
    localparam logic [4:0] PRESCALE_MAX = 5'h1F;
    localparam logic [7:0] BYTE_MAX = 8'hFF;
endpackage

// File: hdl/dtc_timer_core.sv
`timescale 1ns/100ps
module dtc_timer_core
    import dtc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Special function register bus from the core
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    // Interrupt vector acknowledges from the core
    input wire logic vector_ack_first,
    input wire logic vector_ack_second,
    // Device pins
    input wire logic count_input_first,
    input wire logic count_input_second,
    input wire logic gate_pin_first,
    input wire logic gate_pin_second,
    // Overflow requests to the interrupt controller
    output logic overflow_flag_first,
    output logic overflow_flag_second
);
    // Index 0 is the first timer, index 1 the second
    logic [7:0] mode_reg;
    logic [1:0] run_bit;
    logic [1:0] ovf_flag;
    logic [7:0] low_byte [2];
    logic [7:0] high_byte [2];
    logic [1:0] pin_count_s1, pin_count_s2, pin_count_prev;
    logic [1:0] pin_gate_s1, pin_gate_s2;

    wire [1:0] pin_count_raw = {count_input_second, count_input_first};
    wire [1:0] pin_gate_raw = {gate_pin_second, gate_pin_first};

    // Result of one counting step: {constant zero, overflow of the counter, high, low}
    function automatic logic [17:0] step(input logic [1:0] mode, input logic inc,
                                         input logic [7:0] hi, input logic [7:0] lo);
        logic [7:0] nh;
        logic [7:0] nl;
        logic ov;
        nh = hi;
        nl = lo;
        ov = 1'b0;
        if (inc) begin
            unique case (mode)
                MODE_PRESCALED: begin
                    nl = {lo[7:PRESCALE_BITS], lo[PRESCALE_BITS-1:0] + 5'h01};
                    if (lo[PRESCALE_BITS-1:0] == PRESCALE_MAX) begin
                        nh = hi + 8'h01;
                        ov = (hi == BYTE_MAX);
                    end
                end
                MODE_SIXTEEN: begin
                    {nh, nl} = {hi, lo} + 16'h0001;
                    ov = ({hi, lo} == {BYTE_MAX, BYTE_MAX});
                end
                MODE_RELOAD: begin
                    nl = (lo == BYTE_MAX) ? hi : lo + 8'h01;
                    ov = (lo == BYTE_MAX);
                end
                MODE_SPLIT: begin
                    // Only the low byte is handled here; the split high byte is separate
                    nl = lo + 8'h01;
                    ov = (lo == BYTE_MAX);
                end
            endcase
        end
        step = {1'b0, ov, nh, nl};
    endfunction

    // Pins cross into mclk through two flops; for the count pins a third keeps the previous sample
    always_ff @(posedge mclk) begin
        if (srst) begin
            pin_count_s1 <= 2'h0;
            pin_count_s2 <= 2'h0;
            pin_count_prev <= 2'h0;
            pin_gate_s1 <= 2'h0;
            pin_gate_s2 <= 2'h0;
        end else begin
            pin_count_s1 <= pin_count_raw;
            pin_count_s2 <= pin_count_s1;
            pin_count_prev <= pin_count_s2;
            pin_gate_s1 <= pin_gate_raw;
            pin_gate_s2 <= pin_gate_s1;
        end
    end

    // High in one sample, low in the next; at least two clocks per edge, so
    // the source must hold each level a full cycle to be seen
    wire [1:0] fall_edge = pin_count_prev & ~pin_count_s2;

    wire [1:0] gate_sel = {mode_reg[MODE_FIELD_SECOND+MODE_GATE], mode_reg[MODE_FIELD_FIRST+MODE_GATE]};
    wire [1:0] cnt_sel = {mode_reg[MODE_FIELD_SECOND+MODE_COUNTER_SEL],
                          mode_reg[MODE_FIELD_FIRST+MODE_COUNTER_SEL]};
    wire [1:0] mode_second = mode_reg[MODE_FIELD_SECOND+MODE_SEL_HIGH:MODE_FIELD_SECOND+MODE_SEL_LOW];
    wire [1:0] mode_first = mode_reg[MODE_FIELD_FIRST+MODE_SEL_HIGH:MODE_FIELD_FIRST+MODE_SEL_LOW];

    wire enable_first = run_bit[0] & (~gate_sel[0] | pin_gate_s2[0]);
    wire enable_second = run_bit[1] & (~gate_sel[1] | pin_gate_s2[1]);

    // Internal source counts every clock with no divider in front
    wire inc_first = enable_first & (cnt_sel[0] ? fall_edge[0] : 1'b1);
    wire inc_second = enable_second & (cnt_sel[1] ? fall_edge[1] : 1'b1) &
                      (mode_second != MODE_SPLIT);
    wire split_first = (mode_first == MODE_SPLIT);
    // Split high byte is a timer only, steered by the second timer's run bit
    wire inc_split_high = split_first & run_bit[1];

    wire [17:0] res_first = step(mode_first, inc_first, high_byte[0], low_byte[0]);
    wire [17:0] res_second = step(mode_second, inc_second, high_byte[1], low_byte[1]);
    wire [7:0] split_high_next = inc_split_high ? high_byte[0] + 8'h01 : high_byte[0];
    wire split_high_ovf = inc_split_high & (high_byte[0] == BYTE_MAX);

    wire [7:0] next_high_first = split_first ? split_high_next : res_first[15:8];
    wire ovf_event_first = res_first[16];
    // While the first timer is split, its high byte owns the second flag
    wire ovf_event_second = split_first ? split_high_ovf : res_second[16];

    wire wr_control = sfr_wr & (sfr_addr == ADDR_CONTROL);
    wire wr_mode = sfr_wr & (sfr_addr == ADDR_MODE);
    wire wr_low_first = sfr_wr & (sfr_addr == ADDR_LOW_FIRST);
    wire wr_low_second = sfr_wr & (sfr_addr == ADDR_LOW_SECOND);
    wire wr_high_first = sfr_wr & (sfr_addr == ADDR_HIGH_FIRST);
    wire wr_high_second = sfr_wr & (sfr_addr == ADDR_HIGH_SECOND);

    // Flag: hardware set beats both the vector clear and a software write
    wire next_ovf_first = ovf_event_first | (wr_control ? sfr_wdata[CTL_OVF_FIRST] :
                          (ovf_flag[0] & ~vector_ack_first));
    wire next_ovf_second = ovf_event_second | (wr_control ? sfr_wdata[CTL_OVF_SECOND] :
                           (ovf_flag[1] & ~vector_ack_second));

    wire [7:0] control_view = {ovf_flag[1], run_bit[1], ovf_flag[0], run_bit[0], 4'h0};

    logic [7:0] read_mux;
    always_comb begin
        unique case (sfr_addr)
            ADDR_CONTROL: read_mux = control_view;
            ADDR_MODE: read_mux = mode_reg;
            ADDR_LOW_FIRST: read_mux = low_byte[0];
            ADDR_LOW_SECOND: read_mux = low_byte[1];
            ADDR_HIGH_FIRST: read_mux = high_byte[0];
            ADDR_HIGH_SECOND: read_mux = high_byte[1];
            default: read_mux = UNMAPPED_READ;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            mode_reg <= RESET_MODE;
            run_bit <= {RESET_CONTROL[CTL_RUN_SECOND], RESET_CONTROL[CTL_RUN_FIRST]};
            ovf_flag <= 2'h0;
            sfr_rdata <= UNMAPPED_READ;
        end else begin
            if (wr_mode)
                mode_reg <= sfr_wdata;
            if (wr_control)
                run_bit <= {sfr_wdata[CTL_RUN_SECOND], sfr_wdata[CTL_RUN_FIRST]};
            ovf_flag <= {next_ovf_second, next_ovf_first};
            if (sfr_rd)
                sfr_rdata <= read_mux;
        end
    end

    // A software write to a count byte takes priority over counting that cycle
    always_ff @(posedge mclk) begin
        if (srst) begin
            low_byte[0] <= RESET_COUNT;
            low_byte[1] <= RESET_COUNT;
            high_byte[0] <= RESET_COUNT;
            high_byte[1] <= RESET_COUNT;
        end else begin
            low_byte[0] <= wr_low_first ? sfr_wdata : res_first[7:0];
            low_byte[1] <= wr_low_second ? sfr_wdata : res_second[7:0];
            high_byte[0] <= wr_high_first ? sfr_wdata : next_high_first;
            high_byte[1] <= wr_high_second ? sfr_wdata : res_second[15:8];
        end
    end

    assign overflow_flag_first = ovf_flag[0];
    assign overflow_flag_second = ovf_flag[1];
endmodule
